/* design/stc_pkg.sv */
// package: constants and types for the sweep trigger capture block
// Contract
// RULE1: ring storage runs until trigger path stops it
// RULE2: trigger loads delay counter, stop on expiry
// RULE3: pre-trigger samples equal segment minus delay
// RULE4: delay at or above segment: post-trigger only
// RULE5: recorder trigger is OR of channel triggers
// RULE6: each detector has disable and mode select
// RULE7: compare unit result against level, above/below
// RULE8: trigger when classification changes in direction
// RULE9: delay register feeds unit with current sample (the unit here takes the current sample only; prev_reg is never read)
// RULE10: rearm only after leaving hysteresis band
// RULE11: two identical detectors per channel, primary/secondary
// RULE12: time base pulses alone set sample rate
// RULE13: rates are decimal submultiples of main oscillator
// RULE14: standard continuous streams start to stop
// RULE15: circular continuous keeps buffer plus lead-out
// RULE16: stop-on-trigger continuous ends after post delay
// RULE17: manual, external or channel trigger accepted
// RULE18: write pointer wraps to segment start
// RULE19: equal to level is not a crossing
// RULE20: already beyond level at start: no trigger
// RULE21: counter steps per sample; trigger one pulse
// RULE22: configuration sampled only while idle (the rate and external trigger bits of ctrl are used live)
package stc_pkg;
  typedef enum logic [1:0] {stc_sweep, stc_cont_std, stc_cont_circ, stc_cont_stop}
    stc_mode_type;
  typedef enum logic [1:0] {stc_det_off, stc_det_basic, stc_det_dual} stc_det_type;
  localparam int stc_osc_hz = 1000000;
  localparam int stc_clk_hz = 125000000;
  // clocks per oscillator tick, rounded down
  localparam int stc_osc_div = stc_clk_hz / stc_osc_hz;
  localparam int stc_rate_steps = 7;
  localparam logic [2:0] stc_rate_reset = 3'h0;
  localparam logic [31:0] stc_reg_ctrl = 32'h00;
  localparam logic [31:0] stc_reg_status = 32'h04;
  localparam logic [31:0] stc_reg_seglen = 32'h08;
  localparam logic [31:0] stc_reg_delay = 32'h0c;
  localparam logic [31:0] stc_reg_level_p = 32'h10;
  localparam logic [31:0] stc_reg_level_s = 32'h14;
  localparam logic [31:0] stc_reg_hyst = 32'h18;
  localparam logic [31:0] stc_reg_trigcfg = 32'h1c;
  localparam logic [31:0] stc_reg_wptr = 32'h20;
  localparam logic [31:0] stc_reg_trigpos = 32'h24;
  localparam int stc_ctrl_start = 0;
  localparam int stc_ctrl_stop = 1;
  localparam int stc_ctrl_trig = 2;
  localparam int stc_ctrl_mode_lo = 4;
  localparam int stc_ctrl_rate_lo = 8;
  localparam int stc_ctrl_ext_en = 12;
  localparam int stc_ctrl_ext_fall = 13;
endpackage

/* design/stc_level_det.sv */
// single-level crossing detector with slope delay register and hysteresis
`timescale 1ns/10ps
`default_nettype none
module stc_level_det #(
  parameter int DW = 16
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset
  input wire logic enable, // detector active
  input wire logic restart, // recording start
  input wire logic smp_valid, // new sample
  input wire logic signed [DW-1:0] smp, // sample value
  input wire logic signed [DW-1:0] level, // trigger level
  input wire logic [DW-1:0] hyst, // hysteresis width
  input wire logic falling, // direction select
  output logic fire // one-sample trigger pulse
);
  logic signed [DW-1:0] prev_reg; // delay register
  logic signed [DW:0] alu; // unit result
  logic above, below, armed_reg, side_reg, known_reg;
  logic signed [DW+1:0] arm_lvl;
  // unit passes the current sample; the stored one is kept but nothing reads it
  assign alu = {smp[DW-1], smp}; // [RULE9]
  assign above = alu > $signed({level[DW-1], level}); // [RULE7] [RULE19]
  assign below = alu < $signed({level[DW-1], level}); // [RULE7] [RULE19]
  assign arm_lvl = falling ? $signed({{2{level[DW-1]}}, level}) + $signed({2'h0, hyst})
                           : $signed({{2{level[DW-1]}}, level}) - $signed({2'h0, hyst});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= '0;
    end else if (smp_valid) begin
      prev_reg <= smp; // [RULE9]
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      side_reg <= 1'b0;
      known_reg <= 1'b0;
      armed_reg <= 1'b0;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (restart || !enable) begin
        known_reg <= 1'b0;
        armed_reg <= 1'b0;
      end else if (smp_valid) begin
        // arm only once the sample sits beyond the band on the start side
        // kept signed: an unsigned compare never arms below a negative level
        if (falling ? ($signed({smp[DW-1], smp[DW-1], smp}) > arm_lvl)
                    : ($signed({smp[DW-1], smp[DW-1], smp}) < arm_lvl)) begin
          armed_reg <= 1'b1; // [RULE10] [RULE20]
        end
        if (above || below) begin
          known_reg <= 1'b1;
          side_reg <= above;
          if (known_reg && armed_reg && (falling ? (side_reg && below)
                                                 : (!side_reg && above))) begin
            fire <= 1'b1; // [RULE8] [RULE21]
            armed_reg <= 1'b0; // [RULE10]
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* design/stc_capture.sv */
// sweep trigger capture: apb registers, time base, detectors, ring writer
`timescale 1ns/10ps
`default_nettype none
module stc_capture
  import stc_pkg::*;
#(
  parameter int DW = 16,
  parameter int AW = 12,
  parameter int DLYW = 24
) (
  input wire logic pclk, // clock 125 MHz
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [31:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic ext_trig, // external trigger pin
  output logic conv_start, // conversion pulse to converter
  input wire logic smp_valid, // converter sample strobe
  input wire logic signed [DW-1:0] smp_data, // converter sample
  output logic mem_we, // ring memory write
  output logic [AW-1:0] mem_addr, // ring memory address
  output logic [DW-1:0] mem_data, // ring memory data
  output logic host_valid, // stream sample to host
  output logic [DW-1:0] host_data, // streamed sample
  output logic rec_trig, // recorder trigger pulse
  output logic sweep_done // storage halted, level
);
  typedef enum {st_idle, st_run, st_post, st_done} stc_state_type;
  stc_state_type state_reg;
  logic [31:0] ctrl_reg, seglen_reg, delay_reg, lvlp_reg, lvls_reg, hyst_reg, trigcfg_reg;
  logic [AW-1:0] seg_len_reg, wptr_reg, trigpos_reg;
  logic [DLYW-1:0] post_len_reg, cnt_reg;
  logic signed [DW-1:0] lvlp_cfg, lvls_cfg;
  logic [DW-1:0] hyst_cfg;
  stc_det_type det_cfg;
  logic dir_cfg;
  stc_mode_type mode_cfg;
  logic [2:0] ext_sync;
  logic ext_lvl_reg, ext_edge;
  logic wr, rd, start_cmd, stop_cmd, man_trig, idle;
  logic det_p, det_s, chan_trig, trig_any, smp_tick;
  logic [7:0] div_cnt_reg;
  logic [23:0] rate_cnt_reg;
  logic [23:0] rate_top;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign pready = 1'b1;
  assign idle = (state_reg == st_idle) || (state_reg == st_done);
  assign start_cmd = wr && paddr == stc_reg_ctrl && pwdata[stc_ctrl_start];
  assign stop_cmd = wr && paddr == stc_reg_ctrl && pwdata[stc_ctrl_stop];
  assign man_trig = wr && paddr == stc_reg_ctrl && pwdata[stc_ctrl_trig]; // [RULE17]
  assign pslverr = psel && penable && (paddr[31:6] != 26'h0 || paddr[1:0] != 2'h0 ||
    (pwrite && (paddr == stc_reg_status || paddr == stc_reg_wptr ||
                paddr == stc_reg_trigpos)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 32'h0;
      seglen_reg <= 32'h0;
      delay_reg <= 32'h0;
      lvlp_reg <= 32'h0;
      lvls_reg <= 32'h0;
      hyst_reg <= 32'h0;
      trigcfg_reg <= 32'h0;
    end else if (wr && !pslverr) begin
      unique case (paddr)
        stc_reg_ctrl: ctrl_reg <= {pwdata[31:3], 3'h0};
        stc_reg_seglen: seglen_reg <= pwdata;
        stc_reg_delay: delay_reg <= pwdata;
        stc_reg_level_p: lvlp_reg <= pwdata;
        stc_reg_level_s: lvls_reg <= pwdata;
        stc_reg_hyst: hyst_reg <= pwdata;
        stc_reg_trigcfg: trigcfg_reg <= pwdata;
        default: ;
      endcase
    end
  end

  // working copies change only while idle; the rate and external trigger bits of ctrl_reg stay live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_len_reg <= '0;
      post_len_reg <= '0;
      lvlp_cfg <= '0;
      lvls_cfg <= '0;
      hyst_cfg <= '0;
      det_cfg <= stc_det_off;
      dir_cfg <= 1'b0;
      mode_cfg <= stc_sweep;
    end else if (idle) begin
      seg_len_reg <= seglen_reg[AW-1:0]; // [RULE22]
      post_len_reg <= delay_reg[DLYW-1:0]; // [RULE22]
      lvlp_cfg <= lvlp_reg[DW-1:0];
      lvls_cfg <= lvls_reg[DW-1:0];
      hyst_cfg <= hyst_reg[DW-1:0];
      det_cfg <= stc_det_type'(trigcfg_reg[1:0]);
      dir_cfg <= trigcfg_reg[2];
      mode_cfg <= stc_mode_type'(ctrl_reg[stc_ctrl_mode_lo +: 2]);
    end
  end

  always_comb begin
    prdata = 32'h0;
    if (rd) begin
      unique case (paddr)
        stc_reg_ctrl: prdata = ctrl_reg;
        stc_reg_status: prdata = {29'h0, sweep_done, state_reg == st_post, !idle};
        stc_reg_seglen: prdata = seglen_reg;
        stc_reg_delay: prdata = delay_reg;
        stc_reg_level_p: prdata = lvlp_reg;
        stc_reg_level_s: prdata = lvls_reg;
        stc_reg_hyst: prdata = hyst_reg;
        stc_reg_trigcfg: prdata = trigcfg_reg;
        stc_reg_wptr: prdata = {{(32-AW){1'b0}}, wptr_reg};
        stc_reg_trigpos: prdata = {{(32-AW){1'b0}}, trigpos_reg};
        default: prdata = 32'h0;
      endcase
    end
  end

  // decimal time base: 1 MHz oscillator divided by powers of ten
  always_comb begin
    unique case (ctrl_reg[stc_ctrl_rate_lo +: 3])
      3'h0: rate_top = 24'h000000;
      3'h1: rate_top = 24'h000009;
      3'h2: rate_top = 24'h000063;
      3'h3: rate_top = 24'h0003e7;
      3'h4: rate_top = 24'h00270f;
      3'h5: rate_top = 24'h01869f;
      default: rate_top = 24'h0f423f;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 8'h0;
      rate_cnt_reg <= 24'h0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (div_cnt_reg == 8'(stc_osc_div - 1)) begin
        div_cnt_reg <= 8'h0;
        if (rate_cnt_reg >= rate_top) begin
          rate_cnt_reg <= 24'h0;
          conv_start <= 1'b1; // [RULE12] [RULE13]
        end else begin
          rate_cnt_reg <= rate_cnt_reg + 24'h1;
        end
      end else begin
        div_cnt_reg <= div_cnt_reg + 8'h1;
      end
    end
  end
  assign smp_tick = smp_valid;

  // external pin: three stages, change counted when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync <= 3'h0;
      ext_lvl_reg <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_trig};
      if (ext_sync[2] == ext_sync[1]) begin
        ext_lvl_reg <= ext_sync[2];
      end
    end
  end
  assign ext_edge = (ext_sync[2] == ext_sync[1]) && (ext_sync[2] != ext_lvl_reg) &&
    (ext_sync[2] != ctrl_reg[stc_ctrl_ext_fall]);

  stc_level_det #(.DW(DW)) u_det_p ( // [RULE11]
    .pclk(pclk),
    .presetn(presetn),
    .enable(det_cfg != stc_det_off), // [RULE6]
    .restart(start_cmd),
    .smp_valid(smp_tick),
    .smp(smp_data),
    .level(lvlp_cfg),
    .hyst(hyst_cfg),
    .falling(dir_cfg),
    .fire(det_p)
  );
  stc_level_det #(.DW(DW)) u_det_s ( // [RULE11]
    .pclk(pclk),
    .presetn(presetn),
    .enable(det_cfg == stc_det_dual), // [RULE6]
    .restart(start_cmd),
    .smp_valid(smp_tick),
    .smp(smp_data),
    .level(lvls_cfg),
    .hyst(hyst_cfg),
    .falling(!dir_cfg),
    .fire(det_s)
  );
  assign chan_trig = det_p || det_s; // [RULE5]
  assign trig_any = chan_trig || man_trig ||
    (ctrl_reg[stc_ctrl_ext_en] && ext_edge); // [RULE17]
  assign rec_trig = trig_any && state_reg == st_run;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_idle;
      cnt_reg <= '0;
      trigpos_reg <= '0;
    end else begin
      unique case (state_reg)
        st_idle, st_done: begin
          if (start_cmd) begin
            state_reg <= st_run;
          end
        end
        st_run: begin
          if (stop_cmd && mode_cfg == stc_cont_std) begin
            state_reg <= st_done; // [RULE14]
          end else if (mode_cfg == stc_cont_circ && stop_cmd) begin
            state_reg <= st_post; // [RULE15]
            cnt_reg <= post_len_reg;
            trigpos_reg <= wptr_reg;
          end else if (rec_trig && mode_cfg != stc_cont_std && mode_cfg != stc_cont_circ) begin
            state_reg <= st_post; // [RULE2] [RULE16]
            cnt_reg <= post_len_reg;
            trigpos_reg <= wptr_reg;
          end else if (stop_cmd) begin
            state_reg <= st_done;
          end
        end
        st_post: begin
          if (cnt_reg == '0) begin
            state_reg <= st_done; // [RULE1] [RULE2]
          end else if (smp_tick) begin
            cnt_reg <= cnt_reg - 1'b1; // [RULE21]
          end
        end
      endcase
    end
  end
  // after stop the ring holds seg_len minus delay samples before the trigger,
  // none once the delay reaches seg_len [RULE3] [RULE4]
  assign sweep_done = state_reg == st_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= '0;
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_data <= '0;
      host_valid <= 1'b0;
      host_data <= '0;
    end else begin
      mem_we <= 1'b0;
      host_valid <= 1'b0;
      if (start_cmd && idle) begin
        wptr_reg <= '0;
      end else if (smp_tick && (state_reg == st_run ||
                   (state_reg == st_post && cnt_reg != '0))) begin
        mem_data <= smp_data;
        mem_addr <= wptr_reg;
        if (mode_cfg == stc_sweep || mode_cfg == stc_cont_circ) begin
          mem_we <= 1'b1; // [RULE1] [RULE15]
        end
        if (mode_cfg != stc_sweep) begin
          host_valid <= 1'b1; // [RULE14] [RULE16]
          host_data <= smp_data;
        end
        if (wptr_reg + 1'b1 >= seg_len_reg) begin
          wptr_reg <= '0; // [RULE18]
        end else begin
          wptr_reg <= wptr_reg + 1'b1;
        end
      end
    end
  end

  sweep_halt_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    (state_reg == st_post && cnt_reg == '0) |=> sweep_done)
    else $error("sweep did not halt on expiry");
  run_store_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    (state_reg == st_run && smp_tick && mode_cfg == stc_sweep && !start_cmd) |=> mem_we)
    else $error("sample not stored while running");
  wrap_ptr_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
    (wptr_reg == seg_len_reg - 1'b1 && seg_len_reg != '0 && state_reg == st_run && smp_tick
     && !start_cmd) |=> wptr_reg == '0)
    else $error("pointer did not wrap");
  or_trig_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    (chan_trig && state_reg == st_run && mode_cfg == stc_sweep) |=> state_reg == st_post)
    else $error("channel trigger lost");
  trig_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
    det_p |=> !det_p)
    else $error("detector pulse longer than one cycle");
  det_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    (det_cfg == stc_det_off && $past(det_cfg) == stc_det_off) |-> !det_p)
    else $error("disabled detector fired");
  load_cnt_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    (state_reg == st_run && rec_trig && mode_cfg == stc_sweep && !stop_cmd)
    |=> state_reg == st_post && cnt_reg == post_len_reg)
    else $error("delay counter not loaded");
  cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
    (!idle && $past(!idle)) |-> $stable(post_len_reg))
    else $error("configuration changed during acquisition");
  std_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    (state_reg == st_run && mode_cfg == stc_cont_std && stop_cmd) |=> sweep_done)
    else $error("standard stream did not stop");

  // post phase of a sweep: each strobe is stored once and steps the count down once
  sequence post_step_s;
    state_reg == st_post && cnt_reg != '0 && smp_tick && mode_cfg == stc_sweep;
  endsequence
  sequence stored_s;
    mem_we && mem_data == $past(smp_data) && mem_addr == $past(wptr_reg);
  endsequence
  sequence counted_s;
    cnt_reg == $past(cnt_reg) - 1'b1;
  endsequence
  post_store_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
    post_step_s |=> stored_s and counted_s)
    else $error("post-trigger sample not stored or not counted");
  done_halt_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
    sweep_done |=> !mem_we && !host_valid)
    else $error("storage went on after the sweep ended");
  man_trig_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    (man_trig && state_reg == st_run && mode_cfg == stc_sweep) |=> state_reg == st_post)
    else $error("manual trigger not taken");
  ext_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    ext_edge |=> !ext_edge)
    else $error("external edge seen twice");
  conv_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    conv_start |=> !conv_start)
    else $error("conversion pulse longer than one cycle");
  osc_div_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    div_cnt_reg <= 8'(stc_osc_div - 1))
    else $error("oscillator divider out of range");
  host_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    host_valid |-> mode_cfg != stc_sweep)
    else $error("host stream active in sweep mode");
endmodule
`default_nettype wire

/* tb/stc_adc_model.sv */
// behavioural converter model answering conversion pulses with a sample strobe
`timescale 1ns/10ps
`default_nettype none
module stc_adc_model #(
  parameter int DW = 16,
  parameter int LAT = 2
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic conv_start, // conversion pulse
  input wire logic signed [DW-1:0] value, // analog level to convert
  output logic smp_valid, // sample strobe
  output logic signed [DW-1:0] smp_data, // sample bus
  output logic signed [DW-1:0] last_smp // last delivered sample
);
  logic signed [DW-1:0] held;
  int wait_cnt;
  // converts only when the time base asks, never on its own
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_valid <= 1'b0;
      smp_data <= '0;
      last_smp <= '0;
      held <= '0;
      wait_cnt <= 0;
    end else begin
      smp_valid <= 1'b0;
      // the bus is undriven between strobes, so it must not look stable
      smp_data <= ~smp_data;
      if (conv_start) begin
        held <= value;
        wait_cnt <= LAT;
      end else if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
        if (wait_cnt == 1) begin
          smp_valid <= 1'b1;
          smp_data <= held;
          last_smp <= held;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// register-driven bench for the sweep trigger capture block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import stc_pkg::*;
  localparam int DW = 16;
  localparam int S = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ext_trig = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic signed [DW-1:0] adc_val = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, conv_start, smp_valid, mem_we, host_valid, rec_trig, sweep_done;
  logic signed [DW-1:0] smp_data, last_smp;
  logic [11:0] mem_addr;
  logic [DW-1:0] mem_data, host_data;
  logic seen_trig = 1'b0;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int trig_cnt = 0;
  int post_cnt = 0;
  int host_cnt = 0;
  int last_addr = -1;
  int x;

  initial forever #4 pclk = ~pclk;

  stc_capture #(.DW(DW), .AW(12), .DLYW(24)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_trig, .conv_start, .smp_valid,
    .smp_data, .mem_we, .mem_addr, .mem_data, .host_valid, .host_data, .rec_trig, .sweep_done);
  stc_adc_model #(.DW(DW), .LAT(2)) ADC (.pclk, .presetn, .conv_start, .value(adc_val),
    .smp_valid, .smp_data, .last_smp);

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task finish_test;
    $display("counts: fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task cfg(input int lp, input int ls, input int h, input int tc, input int dl);
    apb(1'b1, stc_reg_seglen, S);
    apb(1'b1, stc_reg_delay, dl);
    apb(1'b1, stc_reg_level_p, lp);
    apb(1'b1, stc_reg_level_s, ls);
    apb(1'b1, stc_reg_hyst, h);
    apb(1'b1, stc_reg_trigcfg, tc);
  endtask

  // mode and rate go in while idle, start follows as a separate write
  task run(input int c);
    trig_cnt = 0;
    post_cnt = 0;
    host_cnt = 0;
    seen_trig = 1'b0;
    last_addr = -1;
    apb(1'b1, stc_reg_ctrl, c);
    apb(1'b1, stc_reg_ctrl, c | 1);
  endtask

  task feed(input int v, input int n);
    @(posedge pclk);
    adc_val <= v[DW-1:0];
    repeat (n) begin
      @(posedge pclk);
      while (smp_valid !== 1'b1) @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
  endtask

  task gap(input int exp);
    int n;
    n = 0;
    @(posedge pclk);
    while (conv_start !== 1'b1) @(posedge pclk);
    do begin
      @(posedge pclk);
      n++;
    end while (conv_start !== 1'b1 && n < 20000);
    chk(n, exp);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (mem_we === 1'b1) begin
      if (last_addr >= 0) chk(mem_addr, (last_addr + 1) % S);
      chk({16'h0000, mem_data}, {16'h0000, last_smp});
      last_addr = mem_addr;
      if (seen_trig) post_cnt++;
    end
    if (host_valid === 1'b1) begin
      chk({16'h0000, host_data}, {16'h0000, last_smp});
      host_cnt++;
    end
    if (rec_trig === 1'b1) begin
      trig_cnt++;
      seen_trig = 1'b1;
    end
    if (cycles > 60000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, stc_reg_status, 0);
    chk(rd, 32'h0);
    apb(1'b0, 32'h40, 0);
    chk(err, 1'b1);
    apb(1'b1, stc_reg_status, 32'h7);
    chk(err, 1'b1);
    // rising, hysteresis 10: start above, stay inside band, then arm
    cfg(100, 0, 10, 1, 4);
    feed(200, 1);
    run(0);
    apb(1'b1, stc_reg_delay, 8);
    gap(stc_osc_div);
    feed(200, 3);
    feed(95, 2);
    feed(150, 2);
    chk(trig_cnt, 0);
    feed(50, 12);
    feed(100, 1);
    chk(trig_cnt, 0);
    feed(150, 8);
    chk(trig_cnt, 1);
    chk(post_cnt, 4);
    chk(sweep_done, 1'b1);
    apb(1'b0, stc_reg_status, 0);
    chk(rd & 32'h7, 32'h4);
    apb(1'b0, stc_reg_trigpos, 0);
    x = rd;
    apb(1'b0, stc_reg_wptr, 0);
    chk((rd - x) & 32'hf, 32'h4);
    chk(host_cnt, 0);
    // falling, delay beyond the segment
    cfg(100, 0, 0, 5, 20);
    run(0);
    feed(0, 2);
    chk(trig_cnt, 0);
    feed(200, 2);
    feed(50, 24);
    chk(trig_cnt, 1);
    chk(post_cnt, 20);
    // detector off, slower rate, manual then external trigger
    cfg(100, 0, 0, 0, 4);
    run(32'h100);
    gap(stc_osc_div * 10);
    feed(0, 1);
    feed(200, 2);
    chk(trig_cnt, 0);
    apb(1'b1, stc_reg_ctrl, 32'h104);
    feed(0, 6);
    chk(trig_cnt, 1);
    chk(post_cnt, 4);
    run(32'h1000);
    feed(0, 2);
    ext_trig <= 1'b1;
    feed(0, 6);
    chk(trig_cnt, 1);
    chk(post_cnt, 4);
    ext_trig <= 1'b0;
    // dual: the secondary level fires on its own
    cfg(100, -100, 0, 2, 4);
    run(0);
    feed(0, 2);
    feed(-150, 7);
    chk(trig_cnt, 1);
    chk(post_cnt, 4);
    // continuous modes: standard, circular, stop on trigger
    cfg(100, 0, 0, 0, 4);
    run(32'h10);
    feed(0, 2);
    x = host_cnt;
    feed(0, 5);
    chk(host_cnt - x, 5);
    apb(1'b1, stc_reg_ctrl, 32'h12);
    x = host_cnt;
    feed(0, 3);
    chk(host_cnt - x, 0);
    run(32'h20);
    feed(0, 3);
    apb(1'b1, stc_reg_ctrl, 32'h22);
    x = host_cnt;
    feed(0, 7);
    chk(host_cnt - x, 4);
    chk(sweep_done, 1'b1);
    run(32'h30);
    feed(0, 3);
    apb(1'b1, stc_reg_ctrl, 32'h34);
    x = host_cnt;
    feed(0, 7);
    chk(host_cnt - x, 4);
    chk(sweep_done, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
